// ### common/ccicfg_defines.svh
// constants for the caption inserter channel a configuration register bank
`ifndef CCICFG_DEFINES_SVH
`define CCICFG_DEFINES_SVH

// ==========================================================================
// register offsets
`define CCICFG_OFF_HD_LINE      8'h00
`define CCICFG_OFF_UNUSED_ONE   8'h01
`define CCICFG_OFF_SD_LINE      8'h02
`define CCICFG_OFF_SVC_ONE      8'h03
`define CCICFG_OFF_SVC_TWO      8'h04
`define CCICFG_OFF_LANG_FIRST   8'h05
`define CCICFG_OFF_LANG_SECOND  8'h06
`define CCICFG_OFF_LANG_THIRD   8'h07
`define CCICFG_OFF_TX_FEAT      8'h08
`define CCICFG_OFF_GPI_SD_HOFS  8'h09
`define CCICFG_OFF_GPI_SD_LINE  8'h0a
`define CCICFG_OFF_GPI_HD_LINE  8'h0b
`define CCICFG_OFF_GPI_POL      8'h0f
`define CCICFG_OFF_SPECIAL_TWO  8'h10
`define CCICFG_OFF_REGEN_BLANK  8'h11
`define CCICFG_OFF_GPI_INS_TO   8'h12
`define CCICFG_OFF_GPI_TX_MAP   8'h13
`define CCICFG_OFF_GPI_FLD_MAP  8'h14
`define CCICFG_OFF_MON_CHAN     8'h1d
`define CCICFG_OFF_TIMING_OFS   8'h4d
`define CCICFG_OFF_GPO_ONE_MAP  8'h4e
`define CCICFG_OFF_GPO_TWO_MAP  8'h4f
`define CCICFG_NUM_REGS         22

// ==========================================================================
// reset values
`define CCICFG_RST_HD_LINE      8'h09
`define CCICFG_RST_UNUSED_ONE   8'h13
`define CCICFG_RST_SD_LINE      8'h15
`define CCICFG_RST_SVC_ONE      8'h00
`define CCICFG_RST_SVC_TWO      8'h81
`define CCICFG_RST_LANG_FIRST   8'h65
`define CCICFG_RST_LANG_SECOND  8'h6e
`define CCICFG_RST_LANG_THIRD   8'h67
`define CCICFG_RST_TX_FEAT      8'h00
`define CCICFG_RST_GPI_SD_LINE  8'h0d
`define CCICFG_RST_GPI_HD_LINE  8'h0d
`define CCICFG_RST_ZERO         8'h00

// ==========================================================================
// accepted value ranges
`define CCICFG_HD_LINE_MIN      8'h07
`define CCICFG_HD_LINE_MAX      8'h19
`define CCICFG_SD_LINE_MIN      8'h06
`define CCICFG_SD_LINE_MAX      8'h16
`define CCICFG_LETTER_MIN       8'h61
`define CCICFG_LETTER_MAX       8'h7a
`define CCICFG_ANY_MIN          8'h00
`define CCICFG_ANY_MAX          8'hff

// ==========================================================================
// writable bit masks, unused bits read as zero
`define CCICFG_MASK_ALL         8'hff
`define CCICFG_MASK_SVC_ONE     8'hc0
`define CCICFG_MASK_TX_FEAT     8'hf7
`define CCICFG_MASK_SPECIAL_TWO 8'h38

// ==========================================================================
// field positions
`define CCICFG_BIT_ASPECT       7
`define CCICFG_BIT_EASY_READER  6
`define CCICFG_BIT_DIGITAL      7
`define CCICFG_SVC_NUM_HI       6
`define CCICFG_SVC_NUM_LO       1
`define CCICFG_BIT_FIELD        0
`define CCICFG_BIT_SMPTE333     7
`define CCICFG_BAUD_HI          6
`define CCICFG_BAUD_LO          5
`define CCICFG_BIT_RAW_FMT      4
`define CCICFG_BIT_SD_VANC      2
`define CCICFG_BIT_XDS_OFF      1
`define CCICFG_BIT_HD_VANC_OFF  0
`define CCICFG_VOUT_HI          4
`define CCICFG_VOUT_LO          3
`define CCICFG_BIT_GPI_TX_OR    5

`endif

// ### common/ccicfg_pkg.sv
// types shared by the caption inserter configuration register bank
package ccicfg_pkg;

  // serial speed code of the transmission feature register
  typedef logic [1:0] ccicfg_baud_t;

  // one caption service descriptor as the inserter consumes it
  typedef struct packed {
    logic       wide_aspect;
    logic       easy_reader;
    logic       digital;
    logic [5:0] service_number;
    logic       field_two;
    logic [7:0] lang_first;
    logic [7:0] lang_second;
    logic [7:0] lang_third;
  } ccicfg_service_s;

  // decoded configuration seen by the rest of the inserter
  typedef struct packed {
    logic [7:0]      hd_caption_line;
    logic [7:0]      sd_caption_line;
    ccicfg_service_s service;
    logic            smpte333_enable;
    ccicfg_baud_t    com_speed;
    logic            raw_output;
    logic            sd_vanc_insert;
    logic            smart_xds_enable;
    logic            hd_vanc_enable;
    logic [7:0]      gpi_sd_line;
    logic [7:0]      gpi_hd_line;
    logic [7:0]      gpi_polarity;
    logic            gpi_tx_or_rx;
    logic [1:0]      video_out_mode;
    logic [7:0]      regen_blank;
    logic [7:0]      gpi_insert_timeout;
    logic [7:0]      gpi_tx_map;
    logic [7:0]      monitor_channel;
    logic [7:0]      gpo_one_map;
    logic [7:0]      gpo_two_map;
  } ccicfg_cfg_s;

endpackage

// ### verilog/ccicfg_reg_cell.sv
// one range-checked configuration register
module ccicfg_reg_cell #(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] MIN_VAL = 8'h00,
  parameter logic [7:0] MAX_VAL = 8'hff,
  parameter logic [7:0] MASK    = 8'hff
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // write request from the decoder
  input  wire logic       wr,
  input  wire logic [7:0] wdata,
  // state
  output logic            in_range,
  output logic [7:0]      value
);

  // ==========================================================================
  // range check
  logic [7:0] masked;
  logic [7:0] value_reg;
  logic [7:0] value_next;

  // only the implemented bits take part in the range compare
  assign masked   = wdata & MASK;
  assign in_range = (masked >= MIN_VAL) && (masked <= MAX_VAL);
  // an out-of-range write leaves the old value, so the line never goes illegal
  assign value_next = (wr && in_range) ? masked : value_reg;
  assign value      = value_reg;

  // storage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      value_reg <= RST_VAL;
    end else begin
      value_reg <= value_next;
    end
  end

endmodule

// ### verilog/ccicfg_regs.sv
// channel a configuration register bank of the caption inserter
`include "ccicfg_defines.svh"

// ==========================================================================
// Functional notes
// - hd caption line, range 07-19, reset 09h
// - sd caption line, range 06-16, reset 15h
// - service bit7 aspect: 0 4:3, 1 16:9
// - service bit6 marks easy reader service
// - second service: bit7 digital, bit0 field two
// - bits 6:1 service number when digital, reset 81h
// - three lower-case language letters, reset e,n,g
// - transmission bit7 smpte333 enable, no effect yet
// - transmission bit4 selects raw decoded output
// - transmission bit1 set disables smart xds
// - transmission bit0 set disables hd vanc insertion
// - gpi sd data line, range 06h-16h, reset 0dh
module ccicfg_regs (
  // clock and reset
  input  wire logic                CLK,
  input  wire logic                ARST_N,
  // register access port from the terminal logic
  input  wire logic                REG_WR,
  input  wire logic                REG_RD,
  input  wire logic [7:0]          REG_ADDR,
  input  wire logic [7:0]          REG_WDATA,
  output logic [7:0]               REG_RDATA,
  output logic                     REG_RVALID,
  output logic                     REG_WR_REFUSED,
  // decoded configuration
  output ccicfg_pkg::ccicfg_cfg_s  CFG
);

  // ==========================================================================
  // register table
  localparam int N = `CCICFG_NUM_REGS;

  // index of each register in the table below
  localparam int I_HD    = 0;
  localparam int I_U1    = 1;
  localparam int I_SD    = 2;
  localparam int I_SV1   = 3;
  localparam int I_SV2   = 4;
  localparam int I_L1    = 5;
  localparam int I_L2    = 6;
  localparam int I_L3    = 7;
  localparam int I_TX    = 8;
  localparam int I_HOFS  = 9;
  localparam int I_GSD   = 10;
  localparam int I_GHD   = 11;
  localparam int I_POL   = 12;
  localparam int I_SP2   = 13;
  localparam int I_RGN   = 14;
  localparam int I_GINS  = 15;
  localparam int I_GTX   = 16;
  localparam int I_GFLD  = 17;
  localparam int I_MON   = 18;
  localparam int I_TOFS  = 19;
  localparam int I_GPO1  = 20;
  localparam int I_GPO2  = 21;

  // offsets in index order
  localparam logic [7:0] OFF [N] = '{
    `CCICFG_OFF_HD_LINE,     `CCICFG_OFF_UNUSED_ONE,  `CCICFG_OFF_SD_LINE,
    `CCICFG_OFF_SVC_ONE,     `CCICFG_OFF_SVC_TWO,     `CCICFG_OFF_LANG_FIRST,
    `CCICFG_OFF_LANG_SECOND, `CCICFG_OFF_LANG_THIRD,  `CCICFG_OFF_TX_FEAT,
    `CCICFG_OFF_GPI_SD_HOFS, `CCICFG_OFF_GPI_SD_LINE, `CCICFG_OFF_GPI_HD_LINE,
    `CCICFG_OFF_GPI_POL,     `CCICFG_OFF_SPECIAL_TWO, `CCICFG_OFF_REGEN_BLANK,
    `CCICFG_OFF_GPI_INS_TO,  `CCICFG_OFF_GPI_TX_MAP,  `CCICFG_OFF_GPI_FLD_MAP,
    `CCICFG_OFF_MON_CHAN,    `CCICFG_OFF_TIMING_OFS,  `CCICFG_OFF_GPO_ONE_MAP,
    `CCICFG_OFF_GPO_TWO_MAP
  };

  // reset values; registers with no documented default come up as zero
  localparam logic [7:0] RST [N] = '{
    `CCICFG_RST_HD_LINE,
    `CCICFG_RST_UNUSED_ONE,
    `CCICFG_RST_SD_LINE,
    `CCICFG_RST_SVC_ONE,
    `CCICFG_RST_SVC_TWO,
    `CCICFG_RST_LANG_FIRST,
    `CCICFG_RST_LANG_SECOND,
    `CCICFG_RST_LANG_THIRD,
    `CCICFG_RST_TX_FEAT,
    `CCICFG_RST_ZERO,
    `CCICFG_RST_GPI_SD_LINE,
    `CCICFG_RST_GPI_HD_LINE,
    `CCICFG_RST_ZERO, `CCICFG_RST_ZERO, `CCICFG_RST_ZERO, `CCICFG_RST_ZERO,
    `CCICFG_RST_ZERO, `CCICFG_RST_ZERO, `CCICFG_RST_ZERO, `CCICFG_RST_ZERO,
    `CCICFG_RST_ZERO, `CCICFG_RST_ZERO
  };

  // lowest accepted value
  localparam logic [7:0] MINV [N] = '{
    `CCICFG_HD_LINE_MIN,
    `CCICFG_ANY_MIN,
    `CCICFG_SD_LINE_MIN,
    `CCICFG_ANY_MIN, `CCICFG_ANY_MIN,
    `CCICFG_LETTER_MIN,
    `CCICFG_LETTER_MIN,
    `CCICFG_LETTER_MIN,
    `CCICFG_ANY_MIN, `CCICFG_ANY_MIN,
    `CCICFG_SD_LINE_MIN,
    `CCICFG_HD_LINE_MIN,     // gpi hd line, same span as the caption line
    `CCICFG_ANY_MIN,
    `CCICFG_ANY_MIN,
    `CCICFG_ANY_MIN,
    `CCICFG_ANY_MIN,
    `CCICFG_ANY_MIN,
    `CCICFG_ANY_MIN,
    `CCICFG_ANY_MIN,
    `CCICFG_ANY_MIN,
    `CCICFG_ANY_MIN,
    `CCICFG_ANY_MIN
  };

  // highest accepted value
  localparam logic [7:0] MAXV [N] = '{
    `CCICFG_HD_LINE_MAX,
    `CCICFG_ANY_MAX,
    `CCICFG_SD_LINE_MAX,
    `CCICFG_ANY_MAX, `CCICFG_ANY_MAX,
    `CCICFG_LETTER_MAX,
    `CCICFG_LETTER_MAX,
    `CCICFG_LETTER_MAX,
    `CCICFG_ANY_MAX, `CCICFG_ANY_MAX,
    `CCICFG_SD_LINE_MAX,
    `CCICFG_HD_LINE_MAX,     // gpi hd line, same span as the caption line
    `CCICFG_ANY_MAX,
    `CCICFG_ANY_MAX,
    `CCICFG_ANY_MAX,
    `CCICFG_ANY_MAX,
    `CCICFG_ANY_MAX,
    `CCICFG_ANY_MAX,
    `CCICFG_ANY_MAX,
    `CCICFG_ANY_MAX,
    `CCICFG_ANY_MAX,
    `CCICFG_ANY_MAX
  };

  // implemented bits; unused bits are not stored and read as zero
  localparam logic [7:0] MSK [N] = '{
    `CCICFG_MASK_ALL,         // hd caption line
    `CCICFG_MASK_ALL,         // unused slot
    `CCICFG_MASK_ALL,         // sd caption line
    `CCICFG_MASK_SVC_ONE,
    `CCICFG_MASK_ALL,         // service two
    `CCICFG_MASK_ALL,         // first letter
    `CCICFG_MASK_ALL,         // second letter
    `CCICFG_MASK_ALL,         // third letter
    `CCICFG_MASK_TX_FEAT,
    `CCICFG_MASK_ALL,         // gpi horizontal offset
    `CCICFG_MASK_ALL,         // gpi sd line
    `CCICFG_MASK_ALL,         // gpi hd line
    `CCICFG_MASK_ALL,         // gpi polarity
    `CCICFG_MASK_SPECIAL_TWO, // special features two
    `CCICFG_MASK_ALL,         // regen and blank
    `CCICFG_MASK_ALL,         // gpi insert and timeout
    `CCICFG_MASK_ALL,         // gpi tx mapping
    `CCICFG_MASK_ALL,         // gpi field blank mapping
    `CCICFG_MASK_ALL,         // monitor channel
    `CCICFG_MASK_ALL,         // timing offset
    `CCICFG_MASK_ALL,         // gpo pair one
    `CCICFG_MASK_ALL          // gpo pair two
  };

  // ==========================================================================
  // address decode and register cells
  logic [N-1:0] hit;
  logic [N-1:0] ok;
  logic [7:0]   val  [N];
  logic [7:0]   term [N];
  logic [7:0]   chain [N+1];

  assign chain[0] = 8'h00;

  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : gen_cell
      // one-hot hit on the exact offset
      assign hit[g] = (REG_ADDR == OFF[g]);

      ccicfg_reg_cell #(
        .RST_VAL (RST[g]),
        .MIN_VAL (MINV[g]),
        .MAX_VAL (MAXV[g]),
        .MASK    (MSK[g])
      ) u_cell (
        .clk      (CLK),
        .arst_n   (ARST_N),
        .wr       (REG_WR && hit[g]),
        .wdata    (REG_WDATA),
        .in_range (ok[g]),
        .value    (val[g])
      );

      // read selection as an or-chain of gated values
      assign term[g]    = hit[g] ? val[g] : 8'h00;
      assign chain[g+1] = chain[g] | term[g];
    end
  endgenerate

  // ==========================================================================
  // access answers
  logic       mapped;
  logic       range_hit;
  logic       wr_unlisted;
  logic       wr_out_of_range;
  logic       refuse;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       rvalid_reg;
  logic       refused_reg;

  // an unlisted offset stores nothing and reads back zero
  assign mapped = |hit;
  // range verdict of the addressed cell; only one cell can be hit
  assign range_hit = |(hit & ok);
  // both kinds of refused write share one pulse: software only needs to
  // know that its value did not land, not which check stopped it
  assign wr_unlisted     = REG_WR && !mapped;
  assign wr_out_of_range = REG_WR && mapped && !range_hit;
  assign refuse          = wr_unlisted || wr_out_of_range;
  // a read taken with a write sees the value from before the write
  assign rdata_next = REG_RD ? chain[N] : rdata_reg;

  // registered read data, valid pulse and refusal pulse
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_reg   <= 8'h00;
      rvalid_reg  <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      rdata_reg   <= rdata_next;
      rvalid_reg  <= REG_RD;
      refused_reg <= refuse;
    end
  end

  assign REG_RDATA      = rdata_reg;
  assign REG_RVALID     = rvalid_reg;
  assign REG_WR_REFUSED = refused_reg;

  // ==========================================================================
  // caption line selection
  assign CFG.hd_caption_line = val[I_HD];
  assign CFG.sd_caption_line = val[I_SD];

  // ==========================================================================
  // caption service descriptor
  logic [7:0] sv1;
  logic [7:0] sv2;

  assign sv1 = val[I_SV1];
  assign sv2 = val[I_SV2];

  // aspect and easy reader flags come straight from the first register
  assign CFG.service.wide_aspect = sv1[`CCICFG_BIT_ASPECT];
  assign CFG.service.easy_reader = sv1[`CCICFG_BIT_EASY_READER];
  assign CFG.service.digital     = sv2[`CCICFG_BIT_DIGITAL];
  assign CFG.service.field_two   = sv2[`CCICFG_BIT_FIELD];
  // the service number means nothing for an analog service, so it is forced
  // to zero there rather than passing a stale number downstream
  assign CFG.service.service_number = sv2[`CCICFG_BIT_DIGITAL] ?
      sv2[`CCICFG_SVC_NUM_HI:`CCICFG_SVC_NUM_LO] : 6'h00;
  // language letters are range-held in their cells
  assign CFG.service.lang_first  = val[I_L1];
  assign CFG.service.lang_second = val[I_L2];
  assign CFG.service.lang_third  = val[I_L3];

  // ==========================================================================
  // transmission features
  logic [7:0] txf;

  assign txf = val[I_TX];

  // stored and reported only; nothing acts on it yet
  assign CFG.smpte333_enable = txf[`CCICFG_BIT_SMPTE333];
  // speed code is only held for the terminal; this port is not retimed by it
  assign CFG.com_speed       = txf[`CCICFG_BAUD_HI:`CCICFG_BAUD_LO];
  assign CFG.raw_output      = txf[`CCICFG_BIT_RAW_FMT];
  assign CFG.sd_vanc_insert  = txf[`CCICFG_BIT_SD_VANC];
  // both bits are written as disables, so they are inverted into enables
  assign CFG.smart_xds_enable = !txf[`CCICFG_BIT_XDS_OFF];
  assign CFG.hd_vanc_enable   = !txf[`CCICFG_BIT_HD_VANC_OFF];

  // ==========================================================================
  // gpi and output control
  logic [7:0] sp2;

  assign sp2 = val[I_SP2];

  // gpi lines are range-held in their cells like the caption lines; polarity and map
  // bytes other than the gpi field blank map pass whole, their bit meaning belongs downstream
  assign CFG.gpi_sd_line        = val[I_GSD];
  assign CFG.gpi_hd_line        = val[I_GHD];
  assign CFG.gpi_polarity       = val[I_POL];
  assign CFG.gpi_tx_or_rx       = sp2[`CCICFG_BIT_GPI_TX_OR];
  assign CFG.video_out_mode     = sp2[`CCICFG_VOUT_HI:`CCICFG_VOUT_LO];
  assign CFG.regen_blank        = val[I_RGN];
  assign CFG.gpi_insert_timeout = val[I_GINS];
  assign CFG.gpi_tx_map         = val[I_GTX];
  assign CFG.monitor_channel    = val[I_MON];
  assign CFG.gpo_one_map        = val[I_GPO1];
  assign CFG.gpo_two_map        = val[I_GPO2];

endmodule

// ### testbench/ccicfg_regs_chk.sv
// port assertions for the configuration register bank
module ccicfg_regs_chk (
  // clock and reset
  input wire logic                    CLK,
  input wire logic                    ARST_N,
  // register port
  input wire logic                    REG_WR,
  input wire logic                    REG_RD,
  input wire logic [7:0]              REG_ADDR,
  input wire logic [7:0]              REG_WDATA,
  input wire logic [7:0]              REG_RDATA,
  input wire logic                    REG_RVALID,
  input wire logic                    REG_WR_REFUSED,
  // decoded configuration
  input wire ccicfg_pkg::ccicfg_cfg_s CFG
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // ==========================================================================
  // helpers
  // write data one cycle back, so consequents need no $past on slices
  logic [7:0] d_q;
  always_ff @(posedge CLK) d_q <= REG_WDATA;
  wire logic [7:0] a      = REG_ADDR;
  wire logic       w_hd   = REG_WR && a == 8'h00;
  wire logic       w_sd   = REG_WR && a == 8'h02;
  wire logic       w_s1   = REG_WR && a == 8'h03;
  wire logic       w_s2   = REG_WR && a == 8'h04;
  wire logic       w_l1   = REG_WR && a == 8'h05;
  wire logic       w_tx   = REG_WR && a == 8'h08;
  wire logic       w_gp   = REG_WR && a == 8'h0a;
  wire logic       hd_ok  = d_q >= 8'h07 && d_q <= 8'h19;
  wire logic       sd_ok  = d_q >= 8'h06 && d_q <= 8'h16;
  wire logic       l_ok   = d_q >= 8'h61 && d_q <= 8'h7a;
  wire logic       listed = a <= 8'h0b || (a >= 8'h0f && a <= 8'h14) || a == 8'h1d
                            || (a >= 8'h4d && a <= 8'h4f);
  // ==========================================================================
  // assertions
  property p_hd_line;
    w_hd |=> (hd_ok ? CFG.hd_caption_line == d_q && !REG_WR_REFUSED
                    : REG_WR_REFUSED && $stable(CFG.hd_caption_line));
  endproperty
  a_hd_line: assert property (p_hd_line) else $error("hd line write");
  property p_hd_hold;
    !w_hd |=> $stable(CFG.hd_caption_line);
  endproperty
  a_hd_hold: assert property (p_hd_hold) else $error("hd line moved");
  property p_sd_line;
    w_sd |=> (sd_ok ? CFG.sd_caption_line == d_q && !REG_WR_REFUSED
                    : REG_WR_REFUSED && $stable(CFG.sd_caption_line));
  endproperty
  a_sd_line: assert property (p_sd_line) else $error("sd line write");
  property p_svc_one;
    w_s1 |=> CFG.service.wide_aspect == d_q[7] && CFG.service.easy_reader == d_q[6];
  endproperty
  a_svc_one: assert property (p_svc_one) else $error("service one");
  property p_svc_two;
    w_s2 |=> CFG.service.digital == d_q[7] && CFG.service.field_two == d_q[0]
             && CFG.service.service_number == (d_q[7] ? d_q[6:1] : 6'h00);
  endproperty
  a_svc_two: assert property (p_svc_two) else $error("service two");
  property p_letter;
    w_l1 |=> (l_ok ? CFG.service.lang_first == d_q : REG_WR_REFUSED);
  endproperty
  a_letter: assert property (p_letter) else $error("language letter");
  property p_tx_feat;
    w_tx |=> CFG.smpte333_enable == d_q[7] && CFG.raw_output == d_q[4]
             && CFG.smart_xds_enable == !d_q[1] && CFG.hd_vanc_enable == !d_q[0];
  endproperty
  a_tx_feat: assert property (p_tx_feat) else $error("tx features");
  property p_gpi_line;
    w_gp |=> (sd_ok ? CFG.gpi_sd_line == d_q : REG_WR_REFUSED && $stable(CFG.gpi_sd_line));
  endproperty
  a_gpi_line: assert property (p_gpi_line) else $error("gpi sd line");
  property p_unlisted;
    REG_WR && !listed |=> REG_WR_REFUSED;
  endproperty
  a_unlisted: assert property (p_unlisted) else $error("unlisted write");
  property p_read;
    1'b1 |=> REG_RVALID == $past(REG_RD);
  endproperty
  a_read: assert property (p_read) else $error("read valid timing");
endmodule

bind ccicfg_regs ccicfg_regs_chk i_chk (
  .CLK(CLK), .ARST_N(ARST_N), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
  .REG_WR_REFUSED(REG_WR_REFUSED), .CFG(CFG)
);

// ### testbench/ccicfg_regs_tb.sv
// self-checking bench for the configuration register bank
module ccicfg_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // signals
  logic                    clk;
  logic                    arst_n;
  logic                    reg_wr;
  logic                    reg_rd;
  logic [7:0]              reg_addr;
  logic [7:0]              reg_wdata;
  logic [7:0]              reg_rdata;
  logic                    reg_rvalid;
  logic                    reg_wr_refused;
  ccicfg_pkg::ccicfg_cfg_s cfg;
  int                      fails;
  int                      samples_checked;
  // offset and reset value of every listed register
  logic [15:0] rst_tbl [22] = '{16'h0009, 16'h0113, 16'h0215, 16'h0300, 16'h0481, 16'h0565,
    16'h066e, 16'h0767, 16'h0800, 16'h0900, 16'h0a0d, 16'h0b0d, 16'h0f00, 16'h1000, 16'h1100,
    16'h1200, 16'h1300, 16'h1400, 16'h1d00, 16'h4d00, 16'h4e00, 16'h4f00};
  // offset, lowest and highest accepted value
  logic [23:0] rng_tbl [7] = '{24'h000719, 24'h020616, 24'h05617a, 24'h06617a, 24'h07617a,
    24'h0a0616, 24'h0b0719};
  logic [7:0]  tx_tbl [6]  = '{8'h80, 8'h10, 8'h02, 8'h01, 8'hff, 8'h00};
  logic [7:0]  bad_tbl [6] = '{8'h0c, 8'h0e, 8'h15, 8'h1e, 8'h4c, 8'h50};
  logic [7:0]  map_tbl [7] = '{8'h0f, 8'h11, 8'h12, 8'h13, 8'h1d, 8'h4e, 8'h4f};

  ccicfg_regs i_dut (
    .CLK(clk), .ARST_N(arst_n), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
    .REG_WR_REFUSED(reg_wr_refused), .CFG(cfg)
  );

  // ==========================================================================
  // tasks
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one write, gap cycle after it so the strobe is never raised twice in a step
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ref_exp);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
    check("write refused", {7'h00, ref_exp}, {7'h00, reg_wr_refused});
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check("read valid", 8'h01, {7'h00, reg_rvalid});
    check("read data", exp, reg_rdata);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================================
  // clock and watchdog; the tests need well under 2000 cycles
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("watchdog expired");
    complete_run();
  end

  // ==========================================================================
  // tests
  initial begin
    logic [7:0] a;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] d;
    fails = 0;
    samples_checked = 0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    arst_n = 1'b0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    foreach (rst_tbl[i]) rd(rst_tbl[i][15:8], rst_tbl[i][7:0]);
    $display("test reset values done");
    // boundaries: refused writes must leave the stored value alone
    foreach (rng_tbl[i]) begin
      a  = rng_tbl[i][23:16];
      lo = rng_tbl[i][15:8];
      hi = rng_tbl[i][7:0];
      wr(a, lo - 8'h01, 1'b1);
      wr(a, lo, 1'b0);
      wr(a, hi + 8'h01, 1'b1);
      rd(a, lo);
      wr(a, hi, 1'b0);
      rd(a, hi);
    end
    // each range test ends on its upper bound; all but the first letter's are checked at the outputs
    check("cfg hd line", 8'h19, cfg.hd_caption_line);
    check("cfg sd line", 8'h16, cfg.sd_caption_line);
    check("cfg letters", 8'h7a, cfg.service.lang_second);
    check("cfg letters", 8'h7a, cfg.service.lang_third);
    check("cfg gpi sd line", 8'h16, cfg.gpi_sd_line);
    check("cfg gpi hd line", 8'h19, cfg.gpi_hd_line);
    $display("test value ranges done");
    wr(8'h03, 8'hff, 1'b0);
    rd(8'h03, 8'hc0);
    check("aspect easy", 8'h03, {6'h00, cfg.service.wide_aspect, cfg.service.easy_reader});
    wr(8'h03, 8'h40, 1'b0);
    check("aspect easy", 8'h01, {6'h00, cfg.service.wide_aspect, cfg.service.easy_reader});
    // analog service hides the number field
    wr(8'h04, 8'h7f, 1'b0);
    check("service", 8'h01, {cfg.service.digital, cfg.service.service_number,
                             cfg.service.field_two});
    wr(8'h04, 8'h84, 1'b0);
    check("service", 8'h84, {cfg.service.digital, cfg.service.service_number,
                             cfg.service.field_two});
    $display("test service features done");
    foreach (tx_tbl[i]) begin
      d = tx_tbl[i];
      wr(8'h08, d, 1'b0);
      rd(8'h08, d & 8'hf7);
      check("tx fields", {1'b0, d[7:4], d[2], ~d[1], ~d[0]}, {1'b0, cfg.smpte333_enable,
        cfg.com_speed, cfg.raw_output, cfg.sd_vanc_insert, cfg.smart_xds_enable,
        cfg.hd_vanc_enable});
    end
    $display("test transmission features done");
    // special features two keeps bits 5:3 only; map bytes other than the gpi field blank map pass whole
    wr(8'h10, 8'hff, 1'b0);
    rd(8'h10, 8'h38);
    check("special two", 8'h07, {5'h00, cfg.gpi_tx_or_rx, cfg.video_out_mode});
    foreach (map_tbl[i]) wr(map_tbl[i], map_tbl[i] ^ 8'h5a, 1'b0);
    check("gpi polarity", 8'h55, cfg.gpi_polarity);
    check("regen blank", 8'h4b, cfg.regen_blank);
    check("gpi timeout", 8'h48, cfg.gpi_insert_timeout);
    check("gpi tx map", 8'h49, cfg.gpi_tx_map);
    check("monitor channel", 8'h47, cfg.monitor_channel);
    check("gpo one map", 8'h14, cfg.gpo_one_map);
    check("gpo two map", 8'h15, cfg.gpo_two_map);
    $display("test gpi and output control done");
    foreach (bad_tbl[i]) begin
      wr(bad_tbl[i], 8'h5a, 1'b1);
      rd(bad_tbl[i], 8'h00);
    end
    wr(8'h4d, 8'h5a, 1'b0);
    $display("test unlisted offsets done");
    // reset in mid-run restores defaults
    @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    arst_n <= 1'b1;
    rd(8'h00, 8'h09);
    rd(8'h04, 8'h81);
    check("service reset", 8'h81, {cfg.service.digital, cfg.service.service_number,
                                   cfg.service.field_two});
    check("gpo one reset", 8'h00, cfg.gpo_one_map);
    $display("test second reset done");
    complete_run();
  end
endmodule
